/* hw/cpu_exec_defs.svh */
// Constants for the accumulator and register-pair execution datapath.
// Assumes an AXI4-Lite master with 8-bit byte addresses and 32-bit data.
// How it works
// - Accumulator bits run 0 to 7, bit 0 least significant, rotates included.
// - Pair selects cover B-C, D-E, H-L, stack pointer and status-plus-accumulator.
// - Single increment and decrement add or subtract one on register or H-L byte.
// - Decimal adjust adds 6 per nibble above 9 or with its carry set.
// - Register copy moves source operand into destination, register or H-L byte.
// - Copy with memory as both source and destination is refused.
// - Indirect accumulator store and load use only B-C or D-E addresses.
// - Copy and indirect load/store leave every flag unchanged.
// - Add puts operand plus accumulator in accumulator; carry variant adds carry.
// - Subtract takes operand from accumulator; borrow variant also subtracts carry.
// - Logic ops store AND, XOR or OR of accumulator and operand.
// - Add and subtract update carry, sign, zero, parity and aux carry.
// - Logic ops update sign, zero, parity and always clear carry.
// - Compare sets flags like subtract, keeps accumulator; zero means equal.
// - Circular rotates move the outgoing end bit into carry and other end.
// - Rotates via carry form a nine-bit ring of accumulator and carry.
// - Force carry sets it, invert carry flips it; other flags untouched.
// - Push and pop take B-C, D-E, H-L or the status pair with accumulator.
// - Pair add, increment, decrement take B-C, D-E, H-L or stack pointer.
// - Pair add sums the selected pair into H-L.
// - H-L and D-E swap whole contents in one instruction.
// - Stack pointer load copies H-L into the stack pointer.
// - Push, pair inc/dec, swaps and stack load keep flags; pair add changes carry.
`ifndef CPU_EXEC_DEFS_SVH
`define CPU_EXEC_DEFS_SVH
`define OFS_ACC 8'h00
`define OFS_FLAGS 8'h04
`define OFS_REG_B 8'h08
`define OFS_REG_L 8'h1C
`define OFS_SP 8'h20
`define OFS_EXEC 8'h24
`define OFS_MEM_ADDR 8'h28
`define OFS_MEM_DATA 8'h2C
`define OFS_STATUS 8'h30
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_AC 4
`define FLAG_P 2
`define FLAG_C 0
`define FLAG_KEEP 8'hD5
`define FLAG_ONE 8'h02
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define OPND_FLAGS 3'h6
`define OPND_MEM 3'h6
`define OPND_ACC 3'h7
`define BCD_LIMIT 4'h9
`define BCD_LOW_FIX 9'h006
`define BCD_HIGH_FIX 9'h060
`define OP_IDLE 8'h00
`define OP_FORCE_CARRY 8'h37
`define OP_INVERT_CARRY 8'h3F
`define OP_ACC_INVERT 8'h2F
`define OP_DEC_ADJ 8'h27
`define OP_ROT_LC 8'h07
`define OP_ROT_RC 8'h0F
`define OP_ROT_LV 8'h17
`define OP_ROT_RV 8'h1F
`define OP_HL_DE_SWAP 8'hEB
`define OP_STACK_TOP_SWAP 8'hE3
`define OP_SP_LOAD 8'hF9
`define OP_MEM_TO_MEM 8'h76
`endif

/* hw/cpu_exec_pkg.sv */
// Types shared by the execution datapath.
// Assumes cpu_exec_defs.svh supplies the numeric constants.
package cpu_exec_pkg;
   typedef enum logic [2:0] {
      ALU_ADD = 3'h0, ALU_ADC = 3'h1, ALU_SUB = 3'h2, ALU_SUB_BORROW = 3'h3,
      ALU_AND = 3'h4, ALU_XOR = 3'h5, ALU_OR = 3'h6, ALU_COMPARE = 3'h7
   } alu_op_t;
   typedef enum logic [1:0] {
      PAIR_BC = 2'h0, PAIR_DE = 2'h1, PAIR_HL = 2'h2, PAIR_SP = 2'h3
   } pair_sel_t;
endpackage

/* hw/cpu_alu_instruction_exec.sv */
// Instruction execution datapath with register file, stack and byte memory.
// Assumes an AXI4-Lite master; one write and one read outstanding at most.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "cpu_exec_defs.svh"
module cpu_alu_instruction_exec #(
   parameter int MEM_AW = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic bad_opcode
);
   if (MEM_AW < 1 || MEM_AW > 16) begin : g_bad_aw
      $error("MEM_AW must lie in 1..16");
   end

   // Index order B C D E H L F A; slot 6 is the flag byte, operand 6 is memory
   logic [7:0] rf_q [8];
   logic [7:0] rf_d [8];
   logic [15:0] sp_q, sp_d;
   logic [7:0] mem_q [2**MEM_AW];
   logic [15:0] maddr_q;
   logic [7:0] op_q;
   logic bad_q, bad_d;
   logic wr_q, aw_have_q, w_have_q;
   logic [7:0] wa_q;
   logic [31:0] wd_q;
   logic [3:0] ws_q;
   logic we0, we1;
   logic [15:0] wad0, wad1;
   logic [7:0] wdt0, wdt1;
   logic [15:0] bc, de, hl;
   logic exec;
   logic [7:0] op_w, operand_v;
   logic [31:0] rd_data;
   logic rd_err;

   assign bc = {rf_q[0], rf_q[1]};
   assign de = {rf_q[2], rf_q[3]};
   assign hl = {rf_q[4], rf_q[5]};
   assign op_w = wd_q[7:0];
   assign exec = wr_q && wa_q == `OFS_EXEC && ws_q[0];
   // A process, not an assign: must follow register and memory reads inside opnd
   always_comb begin
      operand_v = opnd(op_w[2:0]);
   end
   assign bad_opcode = bad_q;

   function automatic logic [7:0] mrd(input logic [15:0] a);
      return mem_q[a[MEM_AW-1:0]];
   endfunction

   function automatic logic [7:0] opnd(input logic [2:0] i);
      return (i == `OPND_MEM) ? mrd(hl) : rf_q[i];
   endfunction

   function automatic logic [15:0] pair(input logic [1:0] p);
      case (p)
         cpu_exec_pkg::PAIR_BC: return bc;
         cpu_exec_pkg::PAIR_DE: return de;
         cpu_exec_pkg::PAIR_HL: return hl;
         default: return sp_q;
      endcase
   endfunction

   // Sign, zero, parity and aux carry; aux carry is the bit-4 carry or borrow
   function automatic logic [7:0] szpa(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] r);
      logic [7:0] f;
      f = `FLAG_ONE;
      f[`FLAG_S] = r[7];
      f[`FLAG_Z] = (r == `RST_BYTE);
      f[`FLAG_P] = ~^r;
      f[`FLAG_AC] = a[4] ^ b[4] ^ r[4];
      return f;
   endfunction

   // Returns {flags, result}
   function automatic logic [15:0] alu(input logic [2:0] op, input logic [7:0] a,
                                      input logic [7:0] b, input logic cy);
      logic [8:0] s;
      logic [7:0] f;
      logic cin;
      s = 9'h000;
      cin = (op == cpu_exec_pkg::ALU_ADC || op == cpu_exec_pkg::ALU_SUB_BORROW) ? cy : 1'b0;
      case (op)
         cpu_exec_pkg::ALU_ADD, cpu_exec_pkg::ALU_ADC:
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
         cpu_exec_pkg::ALU_AND: s = {1'b0, a & b};
         cpu_exec_pkg::ALU_XOR: s = {1'b0, a ^ b};
         cpu_exec_pkg::ALU_OR: s = {1'b0, a | b};
         default: s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      endcase
      f = szpa(a, b, s[7:0]);
      f[`FLAG_C] = s[8];
      // Logic results clear carry and aux carry
      if (op == cpu_exec_pkg::ALU_AND || op == cpu_exec_pkg::ALU_XOR ||
          op == cpu_exec_pkg::ALU_OR) begin
         f[`FLAG_C] = 1'b0;
         f[`FLAG_AC] = 1'b0;
      end
      return {f, s[7:0]};
   endfunction

   // Instruction effects, computed from the opcode in the write data
   always_comb begin
      logic [7:0] a, f, v;
      logic [8:0] t;
      logic [15:0] r16, p16;
      logic [16:0] s17;
      for (int i = 0; i < 8; i++) begin
         rf_d[i] = rf_q[i];
      end
      a = rf_q[`OPND_ACC];
      f = rf_q[`OPND_FLAGS];
      v = 8'h00;
      t = 9'h000;
      r16 = 16'h0000;
      p16 = pair(op_w[5:4]);
      s17 = 17'h0_0000;
      sp_d = sp_q;
      bad_d = 1'b0;
      we0 = 1'b0;
      we1 = 1'b0;
      wad0 = hl;
      wad1 = hl;
      wdt0 = 8'h00;
      wdt1 = 8'h00;
      casez (op_w)
         `OP_IDLE: ;
         `OP_FORCE_CARRY: rf_d[`OPND_FLAGS][`FLAG_C] = 1'b1;
         `OP_INVERT_CARRY: rf_d[`OPND_FLAGS][`FLAG_C] = ~f[`FLAG_C];
         `OP_ACC_INVERT: rf_d[`OPND_ACC] = ~a;
         `OP_DEC_ADJ: begin
            t = {1'b0, a};
            if (a[3:0] > `BCD_LIMIT || f[`FLAG_AC]) begin
               t = t + `BCD_LOW_FIX;
            end
            if (t[7:4] > `BCD_LIMIT || f[`FLAG_C] || t[8]) begin
               t = t + `BCD_HIGH_FIX;
            end
            rf_d[`OPND_ACC] = t[7:0];
            rf_d[`OPND_FLAGS] = szpa(a, 8'h00, t[7:0]);
            rf_d[`OPND_FLAGS][`FLAG_C] = f[`FLAG_C] | t[8];
         end
         `OP_ROT_LC: begin
            rf_d[`OPND_ACC] = {a[6:0], a[7]};
            rf_d[`OPND_FLAGS][`FLAG_C] = a[7];
         end
         `OP_ROT_RC: begin
            rf_d[`OPND_ACC] = {a[0], a[7:1]};
            rf_d[`OPND_FLAGS][`FLAG_C] = a[0];
         end
         `OP_ROT_LV: begin
            rf_d[`OPND_ACC] = {a[6:0], f[`FLAG_C]};
            rf_d[`OPND_FLAGS][`FLAG_C] = a[7];
         end
         `OP_ROT_RV: begin
            rf_d[`OPND_ACC] = {f[`FLAG_C], a[7:1]};
            rf_d[`OPND_FLAGS][`FLAG_C] = a[0];
         end
         `OP_HL_DE_SWAP: begin
            {rf_d[4], rf_d[5]} = de;
            {rf_d[2], rf_d[3]} = hl;
         end
         // L with (SP), H with (SP+1)
         `OP_STACK_TOP_SWAP: begin
            rf_d[5] = mrd(sp_q);
            rf_d[4] = mrd(16'(sp_q + 16'h0001));
            we0 = 1'b1;
            wad0 = sp_q;
            wdt0 = rf_q[5];
            we1 = 1'b1;
            wad1 = 16'(sp_q + 16'h0001);
            wdt1 = rf_q[4];
         end
         `OP_SP_LOAD: sp_d = hl;
         `OP_MEM_TO_MEM: bad_d = 1'b1;
         8'b01??_????: begin
            if (op_w[5:3] == `OPND_MEM) begin
               we0 = 1'b1;
               wdt0 = operand_v;
            end else begin
               rf_d[op_w[5:3]] = operand_v;
            end
         end
         8'b000?_0010: begin
            we0 = 1'b1;
            wad0 = p16;
            wdt0 = a;
         end
         8'b000?_1010: rf_d[`OPND_ACC] = mrd(p16);
         8'b00??_?100, 8'b00??_?101: begin
            v = opnd(op_w[5:3]);
            t = {1'b0, op_w[0] ? 8'(v - 8'h01) : 8'(v + 8'h01)};
            rf_d[`OPND_FLAGS] = szpa(v, 8'h00, t[7:0]);
            rf_d[`OPND_FLAGS][`FLAG_C] = f[`FLAG_C];
            if (op_w[5:3] == `OPND_MEM) begin
               we0 = 1'b1;
               wdt0 = t[7:0];
            end else begin
               rf_d[op_w[5:3]] = t[7:0];
            end
         end
         8'b10??_????: begin
            r16 = alu(op_w[5:3], a, operand_v, f[`FLAG_C]);
            rf_d[`OPND_FLAGS] = r16[15:8];
            if (op_w[5:3] != cpu_exec_pkg::ALU_COMPARE) begin
               rf_d[`OPND_ACC] = r16[7:0];
            end
         end
         // push, status pair is A with flags
         8'b11??_0101: begin
            r16 = (op_w[5:4] == 2'h3) ? {a, f} : p16;
            we0 = 1'b1;
            wad0 = 16'(sp_q - 16'h0001);
            wdt0 = r16[15:8];
            we1 = 1'b1;
            wad1 = 16'(sp_q - 16'h0002);
            wdt1 = r16[7:0];
            sp_d = 16'(sp_q - 16'h0002);
         end
         8'b11??_0001: begin
            r16 = {mrd(16'(sp_q + 16'h0001)), mrd(sp_q)};
            if (op_w[5:4] == 2'h3) begin
               rf_d[`OPND_ACC] = r16[15:8];
               rf_d[`OPND_FLAGS] = (r16[7:0] & `FLAG_KEEP) | `FLAG_ONE;
            end else begin
               rf_d[{op_w[5:4], 1'b0}] = r16[15:8];
               rf_d[{op_w[5:4], 1'b1}] = r16[7:0];
            end
            sp_d = 16'(sp_q + 16'h0002);
         end
         // pair sum into H-L, carry only
         8'b00??_1001: begin
            s17 = {1'b0, hl} + {1'b0, p16};
            {rf_d[4], rf_d[5]} = s17[15:0];
            rf_d[`OPND_FLAGS][`FLAG_C] = s17[16];
         end
         8'b00??_0011, 8'b00??_1011: begin
            r16 = op_w[3] ? 16'(p16 - 16'h0001) : 16'(p16 + 16'h0001);
            if (op_w[5:4] == cpu_exec_pkg::PAIR_SP) begin
               sp_d = r16;
            end else begin
               {rf_d[{op_w[5:4], 1'b0}], rf_d[{op_w[5:4], 1'b1}]} = r16;
            end
         end
         default: bad_d = 1'b1;
      endcase
   end

   // register file, stack pointer and bus-side register writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 8; i++) begin
            rf_q[i] <= (i == 6) ? `FLAG_ONE : `RST_BYTE;
         end
         sp_q <= `RST_WORD;
         maddr_q <= `RST_WORD;
         op_q <= `RST_BYTE;
      end else if (exec) begin
         op_q <= op_w;
         if (!bad_d) begin
            for (int i = 0; i < 8; i++) begin
               rf_q[i] <= rf_d[i];
            end
            sp_q <= sp_d;
         end
      end else if (wr_q) begin
         if (ws_q[0]) begin
            case (wa_q)
               `OFS_ACC: rf_q[`OPND_ACC] <= wd_q[7:0];
               `OFS_FLAGS: rf_q[`OPND_FLAGS] <= (wd_q[7:0] & `FLAG_KEEP) | `FLAG_ONE;
               `OFS_SP: sp_q[7:0] <= wd_q[7:0];
               `OFS_MEM_ADDR: maddr_q[7:0] <= wd_q[7:0];
               default: begin
                  if (wa_q >= `OFS_REG_B && wa_q <= `OFS_REG_L) begin
                     rf_q[3'(wa_q[7:2] - 6'h02)] <= wd_q[7:0];
                  end
               end
            endcase
         end
         if (ws_q[1] && wa_q == `OFS_SP) begin
            sp_q[15:8] <= wd_q[15:8];
         end
         if (ws_q[1] && wa_q == `OFS_MEM_ADDR) begin
            maddr_q[15:8] <= wd_q[15:8];
         end
      end
   end

   // Byte memory; refused opcodes never reach the write ports
   always_ff @(posedge aclk) begin
      if (exec && !bad_d) begin
         if (we0) begin
            mem_q[wad0[MEM_AW-1:0]] <= wdt0;
         end
         if (we1) begin
            mem_q[wad1[MEM_AW-1:0]] <= wdt1;
         end
      end else if (wr_q && ws_q[0] && wa_q == `OFS_MEM_DATA) begin
         mem_q[maddr_q[MEM_AW-1:0]] <= wd_q[7:0];
      end
   end

   // Sticky refusal flag; a new refusal wins over a write-one clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bad_q <= 1'b0;
      end else if (exec && bad_d) begin
         bad_q <= 1'b1;
      end else if (wr_q && ws_q[0] && wa_q == `OFS_STATUS && wd_q[0]) begin
         bad_q <= 1'b0;
      end
   end

   function automatic logic mapped(input logic [7:0] ad);
      return ad[1:0] == 2'b00 && ad <= `OFS_STATUS;
   endfunction

   always_comb begin
      rd_err = !mapped(s_axi_araddr);
      rd_data = 32'h0000_0000;
      case (s_axi_araddr)
         `OFS_ACC: rd_data[7:0] = rf_q[`OPND_ACC];
         `OFS_FLAGS: rd_data[7:0] = rf_q[`OPND_FLAGS];
         `OFS_SP: rd_data[15:0] = sp_q;
         `OFS_EXEC: rd_data[7:0] = op_q;
         `OFS_MEM_ADDR: rd_data[15:0] = maddr_q;
         `OFS_MEM_DATA: rd_data[7:0] = mrd(maddr_q);
         `OFS_STATUS: rd_data[0] = bad_q;
         default: begin
            if (s_axi_araddr >= `OFS_REG_B && s_axi_araddr <= `OFS_REG_L && !rd_err) begin
               rd_data[7:0] = rf_q[3'(s_axi_araddr[7:2] - 6'h02)];
            end
         end
      endcase
   end

   // Write channel: address and data taken in either order, then one response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_q <= 1'b0;
         wa_q <= 8'h00;
         wd_q <= 32'h0000_0000;
         ws_q <= 4'h0;
      end else begin
         wr_q <= 1'b0;
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            wa_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
         end
         if (aw_have_q && w_have_q && !s_axi_bvalid) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_q <= mapped(wa_q);
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(wa_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   default clocking dc @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence rot_left_issued;
      exec && op_w == `OP_ROT_LC;
   endsequence
   sequence push_issued;
      exec && op_w[7:6] == 2'b11 && op_w[3:0] == 4'h5;
   endsequence

   AST_FORCE_CARRY: assert property (exec && op_w == `OP_FORCE_CARRY |=>
      rf_q[6][`FLAG_C] && rf_q[6][7:1] == $past(rf_q[6][7:1]))
      else $error("force carry wrong");
   AST_INVERT_CARRY: assert property (exec && op_w == `OP_INVERT_CARRY |=>
      rf_q[6][`FLAG_C] != $past(rf_q[6][`FLAG_C])) else $error("invert carry wrong");
   AST_COPY_FLAGS: assert property (exec && op_w[7:6] == 2'b01 |=>
      $stable(rf_q[6])) else $error("copy changed flags");
   AST_MEM_TO_MEM: assert property (exec && op_w == `OP_MEM_TO_MEM |=>
      bad_q && $stable(sp_q)) else $error("memory to memory copy accepted");
   AST_LOGIC_CARRY: assert property (exec && op_w[7:6] == 2'b10 &&
      op_w[5:3] inside {3'h4, 3'h5, 3'h6} |=> !rf_q[6][`FLAG_C])
      else $error("logic op left carry");
   AST_COMPARE: assert property (exec && op_w[7:3] == 5'b10111 |=>
      $stable(rf_q[7]) && rf_q[6][`FLAG_Z] == ($past(rf_q[7]) == $past(operand_v)))
      else $error("compare wrong");
   AST_ROT_LEFT: assert property (rot_left_issued |=>
      rf_q[7] == {$past(rf_q[7][6:0]), $past(rf_q[7][7])} &&
      rf_q[6][`FLAG_C] == $past(rf_q[7][7])) else $error("circular rotate wrong");
   AST_PUSH_SP: assert property (push_issued |=>
      sp_q == 16'($past(sp_q) - 16'h0002)) else $error("push stack pointer wrong");
   AST_SP_LOAD: assert property (exec && op_w == `OP_SP_LOAD |=>
      sp_q == $past(hl)) else $error("stack load wrong");
   AST_SWAP: assert property (exec && op_w == `OP_HL_DE_SWAP |=>
      hl == $past(de) && de == $past(hl) && $stable(rf_q[6])) else $error("swap wrong");
endmodule

/* verification/axi_lite_master.sv */
// Bus master model for the datapath's AXI4-Lite register port.
// Assumes one calling process; the bench ties strobes and prot.
`timescale 1ns/1ps
module axi_lite_master (
   input wire logic aclk,
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
   end
   // Released lines show the inverse, so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awaddr <= ~a;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wdata <= ~d;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) araddr <= ~a;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

/* verification/tb_cpu_alu_instruction_exec.sv */
// Self-checking bench for the execution datapath.
// Assumes axi_lite_master as the bus partner.
`timescale 1ns/1ps
`include "cpu_exec_defs.svh"
module tb_cpu_alu_instruction_exec;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [1:0] bresp, rresp, resp;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, bad_opcode;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   axi_lite_master bfm (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   cpu_alu_instruction_exec dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bad_opcode(bad_opcode));
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [7:0] a);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: addr %h got %h exp %h", $time, a, g, e);
      end
   endtask
   task automatic put(input logic [7:0] a, input logic [15:0] d);
      bfm.wr(a, 32'(d), resp);
      chk(32'(resp), 32'(`RESP_OKAY), a);
   endtask
   task automatic look(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m = 16'hFFFF);
      bfm.rd(a, rv, resp);
      chk(32'(resp), 32'(`RESP_OKAY), a);
      chk(rv & 32'(m), 32'(e & m), a);
   endtask
   // Operand B is always 6B; flags compared under mask m
   task automatic step(input logic [7:0] op, input logic [7:0] a, input logic [7:0] f,
         input logic [7:0] ea, input logic [7:0] ef, input logic [7:0] m = 8'hFF);
      put(`OFS_ACC, 16'(a));
      put(`OFS_FLAGS, 16'(f));
      put(`OFS_REG_B, 16'h006B);
      put(`OFS_EXEC, 16'(op));
      look(`OFS_ACC, 16'(ea));
      look(`OFS_FLAGS, 16'(ef), 16'(m));
   endtask
   task automatic t_reset();
      look(`OFS_FLAGS, 16'h0002);
      look(`OFS_ACC, 16'h0000);
      look(`OFS_SP, 16'h0000);
      chk(32'(bad_opcode), 32'h0000_0000, 8'hFF);
      $display("reset test done");
   endtask
   task automatic t_acc();
      step(8'h80, 8'h9C, 8'h03, 8'h07, 8'h13);
      step(8'h88, 8'h9C, 8'h03, 8'h08, 8'h13);
      step(8'h90, 8'h9C, 8'h03, 8'h31, 8'h02);
      step(8'h98, 8'h9C, 8'h03, 8'h30, 8'h06);
      step(8'hA0, 8'h9C, 8'h03, 8'h08, 8'h02);
      step(8'hA8, 8'h9C, 8'h03, 8'hF7, 8'h82);
      step(8'hB0, 8'h9C, 8'h03, 8'hFF, 8'h86);
      step(8'hB8, 8'h9C, 8'h03, 8'h9C, 8'h02);
      step(8'hB8, 8'h6B, 8'h02, 8'h6B, 8'h46);
      step(`OP_ROT_LC, 8'h81, 8'hD6, 8'h03, 8'hD7);
      step(`OP_ROT_RC, 8'h81, 8'hD6, 8'hC0, 8'hD7);
      step(`OP_ROT_LV, 8'h81, 8'hD6, 8'h02, 8'hD7);
      step(`OP_ROT_RV, 8'h81, 8'hD6, 8'h40, 8'hD7);
      step(`OP_ROT_LV, 8'h01, 8'hD7, 8'h03, 8'hD6);
      step(`OP_FORCE_CARRY, 8'h81, 8'hD6, 8'h81, 8'hD7);
      step(`OP_INVERT_CARRY, 8'h81, 8'hD7, 8'h81, 8'hD6);
      step(`OP_ACC_INVERT, 8'h81, 8'hD6, 8'h7E, 8'hD6);
      step(`OP_IDLE, 8'h81, 8'hD6, 8'h81, 8'hD6);
      step(`OP_DEC_ADJ, 8'h9B, 8'h02, 8'h01, 8'h01, 8'h01);
      step(8'h3C, 8'hFF, 8'h03, 8'h00, 8'h57);
      step(8'h3D, 8'h00, 8'h02, 8'hFF, 8'h96);
      step(8'h78, 8'h11, 8'hD6, 8'h6B, 8'hD6);
      $display("accumulator test done");
   endtask
   task automatic t_mem();
      put(8'h18, 16'h0000);
      put(`OFS_REG_L, 16'h0040);
      put(`OFS_EXEC, 16'h0070);
      put(`OFS_EXEC, 16'h0034);
      put(`OFS_MEM_ADDR, 16'h0040);
      look(`OFS_MEM_DATA, 16'h006C);
      put(8'h10, 16'h0000);
      put(8'h14, 16'h0050);
      put(`OFS_ACC, 16'h005A);
      put(`OFS_EXEC, 16'h0012);
      put(`OFS_ACC, 16'h0000);
      put(`OFS_REG_B, 16'h0000);
      put(8'h0C, 16'h0050);
      put(`OFS_EXEC, 16'h000A);
      look(`OFS_ACC, 16'h005A);
      put(`OFS_SP, 16'h0080);
      put(`OFS_REG_B, 16'h00AB);
      put(8'h0C, 16'h00CD);
      put(`OFS_EXEC, 16'h00C5);
      look(`OFS_SP, 16'h007E);
      put(`OFS_MEM_ADDR, 16'h007F);
      look(`OFS_MEM_DATA, 16'h00AB);
      put(`OFS_EXEC, 16'h00D1);
      look(8'h10, 16'h00AB);
      look(8'h14, 16'h00CD);
      look(`OFS_SP, 16'h0080);
      put(`OFS_SP, 16'h007E);
      put(`OFS_EXEC, 16'(`OP_STACK_TOP_SWAP));
      look(`OFS_REG_L, 16'h00CD);
      look(8'h18, 16'h00AB);
      look(`OFS_MEM_DATA, 16'h0000);
      look(`OFS_SP, 16'h007E);
      put(`OFS_EXEC, 16'(`OP_STACK_TOP_SWAP));
      look(`OFS_REG_L, 16'h0040);
      put(`OFS_EXEC, 16'(`OP_HL_DE_SWAP));
      look(8'h18, 16'h00AB);
      look(8'h14, 16'h0040);
      put(`OFS_EXEC, 16'h0019);
      look(`OFS_REG_L, 16'h000D);
      look(`OFS_FLAGS, 16'h0006);
      put(`OFS_EXEC, 16'(`OP_SP_LOAD));
      put(`OFS_EXEC, 16'h0033);
      look(`OFS_SP, 16'hAC0E);
      $display("memory and pair test done");
   endtask
   task automatic t_refuse();
      put(`OFS_ACC, 16'h0033);
      put(`OFS_EXEC, 16'(`OP_MEM_TO_MEM));
      look(`OFS_STATUS, 16'h0001);
      chk(32'(bad_opcode), 32'h0000_0001, 8'hFF);
      look(`OFS_ACC, 16'h0033);
      look(`OFS_EXEC, 16'h0076);
      put(`OFS_STATUS, 16'h0001);
      look(`OFS_STATUS, 16'h0000);
      put(`OFS_EXEC, 16'h00FE);
      look(`OFS_STATUS, 16'h0001);
      look(`OFS_EXEC, 16'h00FE);
      bfm.rd(8'h34, rv, resp);
      chk(32'(resp), 32'(`RESP_SLVERR), 8'h34);
      $display("refused opcode test done");
   endtask
   initial begin
      forever #20 aclk = ~aclk;
   end
   // Ceiling well above the roughly 700 cycles the tests need
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 8000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_reset();
      t_acc();
      t_mem();
      t_refuse();
      final_report();
   end
endmodule
